// [converter_load_meas_mode_ctrl.sv]
// Load current measurement, converter mode and spread spectrum control
`timescale 1ns/1ns
module converter_load_meas_mode_ctrl #(
  parameter int MEAS_CYCLES_P = clms_pkg::MEAS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire clms_pkg::clms_bus_s bus,
  output logic [7:0] rdata,
  input wire clms_pkg::clms_otp_s otp,
  input wire logic [1:0] buckHeavyLoad,
  input wire logic [8:0] adcResult,
  output clms_pkg::clms_conv_s conv,
  output logic intRequest
);
  import clms_pkg::*;

  typedef struct packed {
    clms_state_e state;
    logic [15:0] cnt;
    logic sel;
    logic [RESULT_W-1:0] result;
    logic doneFlag;
    logic [7:0] maskTop;
    logic [7:0] config_;
    logic [7:0] pllCtrl;
    logic [7:0] buck0;
    logic [7:0] buck1;
    logic [7:0] boost;
    logic [7:0] measCfg;
    logic otpLoaded;
    logic boostBypass;
    logic [3:0] spread;
    logic [1:0] heavyA;
    logic [1:0] heavyB;
    logic [7:0] rdata;
  } clms_state_s;

  clms_state_s s_q;
  clms_state_s s_d;
  logic measEnd;
  logic [15:0] measLast;
  logic spreadOk;
  logic [4:0] syncFreq;

  // Cycle count is shortened for simulation through the parameter
  assign measLast = 16'(MEAS_CYCLES_P - 1);
  assign measEnd = (s_q.state == MS_RUN) && (s_q.cnt == measLast);
  // Spread allowed only on internal RC oscillator
  assign spreadOk = s_q.config_[CFG_SPREAD_BIT] & ~s_q.pllCtrl[PLL_EN_BIT];
  // Out-of-range sync settings clamp to the top step
  assign syncFreq = (s_q.pllCtrl[4:0] > SYNC_FREQ_MAX) ? SYNC_FREQ_MAX : s_q.pllCtrl[4:0];

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.heavyA = buckHeavyLoad;
    s_d.heavyB = s_q.heavyA;
    // Defaults captured once after reset, not under reset
    if (!s_q.otpLoaded) begin
      s_d.otpLoaded = 1'b1;
      s_d.buck0 = otp.buck0Ctrl;
      s_d.buck1 = otp.buck1Ctrl;
      s_d.boost = {3'h0, 1'b1, otp.boostIlim, otp.boostVset};
      s_d.boost[BOOST_DIS_BIT + 2] = 1'b1;
      s_d.boostBypass = otp.boostBypass;
    end
    // Modulation ramp walks down from fsw to 0.85 fsw, then wraps back to fsw
    if (spreadOk) begin
      s_d.spread = s_q.spread + 4'h1;
    end else begin
      s_d.spread = 4'h0;
    end
    // Measurement sequencer
    case (s_q.state)
      MS_IDLE: begin
        s_d.cnt = 16'h0000;
      end
      MS_RUN: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (measEnd) begin
          s_d.state = MS_LATCH;
        end
      end
      MS_LATCH: begin
        s_d.result = adcResult;
        s_d.state = MS_IDLE;
        if (s_q.measCfg[MCFG_INT_EN_BIT]) begin
          s_d.doneFlag = 1'b1;
        end
      end
      default: begin
        s_d.state = MS_IDLE;
      end
    endcase
    // Read path, data valid the cycle after the strobe
    s_d.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        REG_SEL_LOAD: s_d.rdata = {7'h00, s_q.sel};
        REG_RESULT_LO: s_d.rdata = s_q.result[7:0];
        REG_RESULT_HI: s_d.rdata = {7'h00, s_q.result[8]};
        REG_INT_TOP: s_d.rdata = {7'h00, s_q.doneFlag};
        REG_MASK_TOP: s_d.rdata = s_q.maskTop;
        REG_CONFIG: s_d.rdata = s_q.config_;
        REG_PLL_CTRL: s_d.rdata = s_q.pllCtrl;
        REG_BUCK0_CTRL: s_d.rdata = s_q.buck0;
        REG_BUCK1_CTRL: s_d.rdata = s_q.buck1;
        REG_BOOST_CTRL: s_d.rdata = s_q.boost;
        REG_MEAS_CFG: s_d.rdata = s_q.measCfg;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Write path; a write to REG_SEL_LOAD restarts even a running measurement
    if (bus.wr) begin
      case (bus.addr)
        REG_SEL_LOAD: begin
          s_d.sel = bus.wdata[SEL_BUCK_BIT];
          s_d.state = MS_RUN;
          s_d.cnt = 16'h0000;
        end
        REG_INT_TOP: begin
          // Write one to clear; a completion in the same cycle wins
          if (bus.wdata[INT_DONE_BIT] &&
              !(s_q.state == MS_LATCH && s_q.measCfg[MCFG_INT_EN_BIT])) begin
            s_d.doneFlag = 1'b0;
          end
        end
        REG_MASK_TOP: s_d.maskTop = bus.wdata;
        REG_CONFIG: s_d.config_ = bus.wdata;
        REG_PLL_CTRL: s_d.pllCtrl = bus.wdata;
        REG_BUCK0_CTRL: s_d.buck0 = bus.wdata;
        REG_BUCK1_CTRL: s_d.buck1 = bus.wdata;
        // Bypass mode cannot change on the fly, only OTP sets it
        REG_BOOST_CTRL: s_d.boost = bus.wdata;
        REG_MEAS_CFG: s_d.measCfg = bus.wdata;
        default: begin
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.state <= MS_IDLE;
      s_q.maskTop <= RST_MASK_TOP;
      s_q.config_ <= RST_CONFIG;
      s_q.pllCtrl <= RST_PLL_CTRL;
      s_q.measCfg <= RST_MEAS_CFG;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs; result code times 20 mA gives load current
  always_comb begin
    conv = '0;
    conv.measActive = (s_q.state != MS_IDLE);
    conv.measBuck = s_q.sel;
    // Auto mode picks PWM under heavy load; forced PWM and measurement override
    conv.buckPwm[0] = s_q.buck0[BUCK_FPWM_BIT] | s_q.heavyB[0]
      | (conv.measActive & ~s_q.sel);
    conv.buckPwm[1] = s_q.buck1[BUCK_FPWM_BIT] | s_q.heavyB[1]
      | (conv.measActive & s_q.sel);
    conv.boostPwm = 1'b1;
    conv.boostVset = s_q.boost[1:0];
    conv.boostIlim = s_q.boost[3:2];
    conv.boostBypass = s_q.boostBypass;
    conv.stepUpDischargeEnable = s_q.boost[BOOST_DIS_BIT + 2];
    conv.freqSpreadEnable = spreadOk;
    // Gated so a stale ramp value never shows in the cycle the enable drops
    conv.spreadStep = spreadOk ? s_q.spread : 4'h0;
    conv.syncFreqSel = syncFreq;
    conv.pllEnable = s_q.pllCtrl[PLL_EN_BIT];
  end

  assign rdata = s_q.rdata;
  assign intRequest = s_q.doneFlag & ~s_q.maskTop[MASK_DONE_BIT];
endmodule

// [clms_pkg.sv]
// Package with constants, register map and state types for the load measurement controller
package clms_pkg;
  // Register offsets
  localparam logic [7:0] REG_SEL_LOAD = 8'h00;
  localparam logic [7:0] REG_RESULT_LO = 8'h01;
  localparam logic [7:0] REG_RESULT_HI = 8'h02;
  localparam logic [7:0] REG_INT_TOP = 8'h03;
  localparam logic [7:0] REG_MASK_TOP = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h05;
  localparam logic [7:0] REG_PLL_CTRL = 8'h06;
  localparam logic [7:0] REG_BUCK0_CTRL = 8'h07;
  localparam logic [7:0] REG_BUCK1_CTRL = 8'h08;
  localparam logic [7:0] REG_BOOST_CTRL = 8'h09;
  localparam logic [7:0] REG_MEAS_CFG = 8'h0a;
  // Field positions
  localparam int SEL_BUCK_BIT = 0;
  localparam int INT_DONE_BIT = 0;
  localparam int MASK_DONE_BIT = 0;
  localparam int CFG_SPREAD_BIT = 0;
  localparam int PLL_EN_BIT = 5;
  localparam int MCFG_INT_EN_BIT = 0;
  localparam int BUCK_FPWM_BIT = 0;
  localparam int BOOST_DIS_BIT = 2;
  // Reset values and the step-up voltage setting limit
  localparam logic [7:0] RST_MASK_TOP = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_PLL_CTRL = 8'h00;
  localparam logic [7:0] RST_MEAS_CFG = 8'h01;
  localparam logic [1:0] STEP_UP_VOLTAGE_SETTING_MAX = 2'h3;
  // Physical scaling
  localparam int RESULT_STEP_MA = 20;
  localparam int AUTO_PWM_THRESH_MA = 520;
  localparam int SPREAD_MIN_PERMILLE = 850;
  localparam int SPREAD_STEPS = 16;
  localparam logic [4:0] SYNC_FREQ_MAX = 5'h17;
  // Measurement time
  localparam int MEAS_TIME_US = 50;
  localparam int CLK_MHZ = 100;
  localparam int MEAS_CYCLES = MEAS_TIME_US * CLK_MHZ;
  localparam int RESULT_W = 9;

  typedef enum logic [1:0] {MS_IDLE, MS_RUN, MS_LATCH} clms_state_e;

  // Software register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } clms_bus_s;

  // OTP defaults
  typedef struct packed {
    logic [7:0] buck0Ctrl;
    logic [7:0] buck1Ctrl;
    logic [1:0] boostVset;
    logic [1:0] boostIlim;
    logic boostBypass;
  } clms_otp_s;

  // Converter control outputs
  typedef struct packed {
    logic [1:0] buckPwm;
    logic boostPwm;
    logic [1:0] boostVset;
    logic [1:0] boostIlim;
    logic boostBypass;
    logic stepUpDischargeEnable;
    logic freqSpreadEnable;
    logic [3:0] spreadStep;
    logic [4:0] syncFreqSel;
    logic pllEnable;
    logic measActive;
    logic measBuck;
  } clms_conv_s;
endpackage

// [clms_checker.sv]
// Port assertions for the load measurement controller
`timescale 1ns/1ns
module clms_checker #(
  parameter int MEAS_CYCLES_P = clms_pkg::MEAS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire clms_pkg::clms_bus_s bus,
  input wire logic [7:0] rdata,
  input wire clms_pkg::clms_otp_s otp,
  input wire logic [1:0] buckHeavyLoad,
  input wire logic [8:0] adcResult,
  input wire clms_pkg::clms_conv_s conv,
  input wire logic intRequest
);
  import clms_pkg::*;
  localparam int RUN_MAX = MEAS_CYCLES_P + 1;
  logic [15:0] runCnt;
  logic selWr;
  logic selBit;
  // Selection write and the chosen buck bit
  assign selWr = bus.wr && bus.addr == REG_SEL_LOAD;
  assign selBit = bus.wdata[SEL_BUCK_BIT];
  // Counts active cycles of one run; a restart zeroes it so runs never merge
  always_ff @(posedge mclk) begin
    if (rst || selWr || !conv.measActive) begin
      runCnt <= '0;
    end else begin
      runCnt <= runCnt + 16'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence heavyHeld;
    buckHeavyLoad[0] [*3];
  endsequence
  a_meas_start: assert property (selWr |=> conv.measActive && conv.measBuck == $past(selBit))
    else $error("measurement did not start on the selected buck");
  a_forced_pwm: assert property (conv.measActive |-> conv.buckPwm[conv.measBuck])
    else $error("measured buck not in PWM");
  a_meas_length: assert property ($fell(conv.measActive) |-> runCnt == RUN_MAX)
    else $error("measurement length wrong");
  a_heavy_pwm: assert property (heavyHeld |-> conv.buckPwm[0])
    else $error("heavy load buck not in PWM");
  a_boost_pwm: assert property (conv.boostPwm)
    else $error("boost left PWM");
  a_spread_gate: assert property (conv.freqSpreadEnable |-> !conv.pllEnable)
    else $error("spread active with PLL on");
  a_spread_idle: assert property (!conv.freqSpreadEnable |-> conv.spreadStep == 4'h0)
    else $error("spread ramp moving while off");
  a_sync_clamp: assert property (conv.syncFreqSel <= SYNC_FREQ_MAX)
    else $error("sync frequency out of range");
  a_bypass_otp: assert property (!$past(rst) |-> conv.boostBypass == otp.boostBypass)
    else $error("boost mode differs from fixed setting");
endmodule

bind converter_load_meas_mode_ctrl clms_checker #(.MEAS_CYCLES_P(MEAS_CYCLES_P)) i_chk (
  .mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .otp(otp),
  .buckHeavyLoad(buckHeavyLoad), .adcResult(adcResult), .conv(conv),
  .intRequest(intRequest));

// [converter_load_meas_mode_ctrl_test.sv]
// Self-checking bench for the load measurement controller
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module converter_load_meas_mode_ctrl_test;
  import clms_pkg::*;
  localparam int MC = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  clms_bus_s bus = '0;
  logic [7:0] rdata;
  clms_otp_s otp = '{8'h5a, 8'h3c, 2'h2, 2'h1, 1'b1};
  logic [1:0] buckHeavyLoad = 2'h0;
  logic [8:0] adcResult = 9'h0;
  clms_conv_s conv;
  logic intRequest;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'hf17fcabe;
  int res = 0;
  int msk = 0;
  int r;
  logic [7:0] v;
  // Free-running 100 MHz clock
  always #5 mclk = ~mclk;
  converter_load_meas_mode_ctrl #(.MEAS_CYCLES_P(MC)) i_dut (.mclk(mclk), .rst(rst),
    .bus(bus), .rdata(rdata), .otp(otp), .buckHeavyLoad(buckHeavyLoad),
    .adcResult(adcResult), .conv(conv), .intRequest(intRequest));
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  // One-cycle read; data is only valid in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic meas(input int b);
    int n;
    int prev;
    prev = res;
    res = $random(seed) & 32'h1ff;
    adcResult <= res[8:0];
    wr(REG_SEL_LOAD, 8'(b));
    rd(REG_RESULT_LO);
    `CHK(v, 8'(prev))
    n = 2;
    while (conv.measActive === 1'b1 && n < 100) begin
      @(posedge mclk);
      #1 n++;
    end
    `CHK(n, MC + 1)
    `CHK(conv.buckPwm, 2'b00)
    rd(REG_RESULT_LO);
    `CHK(v, 8'(res))
    rd(REG_RESULT_HI);
    `CHK(v[0], res[8])
    rd(REG_INT_TOP);
    `CHK({v[0], intRequest}, {1'b1, msk == 0})
    wr(REG_INT_TOP, 8'h01);
    rd(REG_INT_TOP);
    `CHK({v[0], intRequest}, 2'b00)
    $display("test meas buck %0d mask %0d done", b, msk);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog well past the expected run length
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(REG_BUCK0_CTRL);
    `CHK(v, otp.buck0Ctrl)
    rd(REG_BOOST_CTRL);
    `CHK(v, {3'h0, 1'b1, otp.boostIlim, otp.boostVset})
    rd(REG_MEAS_CFG);
    `CHK(v, RST_MEAS_CFG)
    rd(8'h20);
    `CHK(v, 8'h00)
    $display("test reset values done");
    wr(REG_BUCK0_CTRL, 8'h00);
    wr(REG_BUCK1_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      msk = i >> 1;
      wr(REG_MASK_TOP, 8'(msk));
      meas(i & 1);
    end
    wr(REG_SEL_LOAD, 8'h00);
    repeat (5) @(posedge mclk);
    meas(1);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      wr(REG_BUCK0_CTRL, 8'(i & 1));
      buckHeavyLoad <= r[1:0];
      repeat (3) @(posedge mclk);
      #1 `CHK(conv.buckPwm, {r[1], r[0] | i[0]})
      wr(REG_PLL_CTRL, {2'h0, i[1], r[6:2]});
      wr(REG_CONFIG, 8'(i & 1));
      wr(REG_BOOST_CTRL, r[15:8]);
      #1 `CHK(conv.freqSpreadEnable, i[0] & !i[1])
      `CHK(conv.syncFreqSel, (r[6:2] > 23) ? 5'h17 : r[6:2])
      `CHK(conv.spreadStep, (i[0] & !i[1]) ? 4'h2 : 4'h0)
      `CHK({conv.boostVset, conv.stepUpDischargeEnable}, {r[9:8], r[12]})
    end
    $display("test modes and spread done");
    complete_run();
  end
endmodule
